// ### usr_sync_rx.sv
/*
 * synchronous serial port, master and slave reception, with an AXI4-Lite
 * register slave.
 * assumes: mclk 50 MHz; the link clock and data pins are asynchronous to
 * mclk and far slower (link clock period well above 4 mclk periods).
 */
// Decided for this implementation: register access over AXI4-Lite.
// Functional notes
// - pins used only with enable and directions set
// - async, sync master, sync slave modes
// - single or continuous enable starts reception
// - data sampled on serial clock falling edge
// - single enable receives one word, stops
// - continuous enable receives until cleared or until overrun
// - both enables set behaves as continuous
// - finished word moves into fifo if room
// - word moved sets done flag; enable gates irq
// - done flag read-only, clears when fifo empty
// - receive fifo holds two words
// - third word into full fifo sets overrun
// - overrun cleared only by clearing continuous enable
// - overrun blocks shift register to fifo moves
// - ninth bit queued with word, read first
// - irq also needs global and peripheral enables
`include "usr_defines.svh"

module usr_sync_rx #(
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        clock_line_pin_in,
    output logic             clock_line_pin_out_ff,
    output logic             clock_line_pin_oe_n_ff,
    input  wire logic        data_line_pin_in,
    output logic             data_line_pin_out_ff,
    output logic             data_line_pin_oe_n_ff,
    output logic             rx_irq_ff,
    output logic             tx_nine_bit_mode_ff,
    output logic             tx_ninth_bit_value_ff
);
    import usr_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [7:0]  tx_ctl_ff;
    logic        port_en_ff, rx_nine_ff, single_en_ff, cont_en_ff, overrun_ff;
    logic [7:0]  baud_div_ff;
    logic [2:0]  irq_ctl_ff;
    logic [7:0]  port_dir_ff;
    logic        aw_held_ff, w_held_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] wr_data_ff;
    logic [3:0]  wr_strb_ff;
    logic [2:0]  clk_sync_ff;
    logic [1:0]  dat_sync_ff;
    usr_rx_state_type rx_state_ff;
    logic [7:0]  baud_cnt_ff;
    logic [3:0]  bit_cnt_ff;
    logic [8:0]  shreg_ff;
    usr_mode_type mode;
    logic        do_write, wr_lane, ar_take, rd_pop, rd_hit;
    logic        port_ok, rx_go, master, fall_stb, last_bit, word_end, push;
    logic        rx_done;
    logic [8:0]  word_in, fifo_head;
    logic [31:0] rd_mux;
    logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_count;
    logic        fifo_full;

    // ------------------------------------------------------------------
    // mode and pin ownership
    // ------------------------------------------------------------------
    always_comb begin
        if (!tx_ctl_ff[`USR_TX_SYNC]) begin
            mode = USR_MODE_ASYNC;
        end else if (tx_ctl_ff[`USR_TX_MASTER]) begin
            mode = USR_MODE_SYNC_MASTER;
        end else begin
            mode = USR_MODE_SYNC_SLAVE;
        end
    end

    assign port_ok = port_en_ff && port_dir_ff[`USR_PD_CLK]
                     && port_dir_ff[`USR_PD_DAT];
    assign master  = (mode == USR_MODE_SYNC_MASTER);
    // the async datapath lives elsewhere; high baud select has no say here
    assign rx_go   = (mode != USR_MODE_ASYNC) && port_ok && (single_en_ff || cont_en_ff)
                     && !overrun_ff;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_line_pin_oe_n_ff <= 1'b1;
            data_line_pin_oe_n_ff  <= 1'b1;
            data_line_pin_out_ff   <= 1'b0;
        end else if (clk_en) begin
            // only a sync master drives the clock; data is always input here
            clock_line_pin_oe_n_ff <= !(port_ok && master);
            data_line_pin_oe_n_ff  <= 1'b1;
            data_line_pin_out_ff   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_sync_ff <= 3'h0;
            dat_sync_ff <= 2'h0;
        end else if (clk_en) begin
            clk_sync_ff <= {clk_sync_ff[1:0], clock_line_pin_in};
            dat_sync_ff <= {dat_sync_ff[0], data_line_pin_in};
        end
    end

    // ------------------------------------------------------------------
    // receive engine
    // ------------------------------------------------------------------
    assign fall_stb = (rx_state_ff == USR_RX_SHIFT) && (master
                      ? (baud_cnt_ff == baud_div_ff && clock_line_pin_out_ff)
                      : (clk_sync_ff[2] && !clk_sync_ff[1]));
    assign last_bit = (bit_cnt_ff == (rx_nine_ff ? 4'h8 : 4'h7));
    assign word_end = fall_stb && last_bit;
    assign word_in  = rx_nine_ff ? {dat_sync_ff[1], shreg_ff[8:1]}
                                 : {1'b0, dat_sync_ff[1], shreg_ff[8:2]};
    assign push     = word_end && !fifo_full && !overrun_ff;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state_ff           <= USR_RX_IDLE;
            baud_cnt_ff           <= 8'h00;
            bit_cnt_ff            <= 4'h0;
            shreg_ff              <= 9'h000;
            clock_line_pin_out_ff <= 1'b0;
        end else if (clk_en) begin
            if (!rx_go) begin
                rx_state_ff           <= USR_RX_IDLE;
                baud_cnt_ff           <= 8'h00;
                bit_cnt_ff            <= 4'h0;
                clock_line_pin_out_ff <= 1'b0;
            end else begin
                case (rx_state_ff)
                    USR_RX_IDLE: begin
                        rx_state_ff <= USR_RX_SHIFT;
                        baud_cnt_ff <= 8'h00;
                        bit_cnt_ff  <= 4'h0;
                    end
                    USR_RX_SHIFT: begin
                        if (!master) begin
                            clock_line_pin_out_ff <= 1'b0;
                        end else if (baud_cnt_ff == baud_div_ff) begin
                            baud_cnt_ff           <= 8'h00;
                            clock_line_pin_out_ff <= !clock_line_pin_out_ff;
                        end else begin
                            baud_cnt_ff <= baud_cnt_ff + 8'h01;
                        end
                        if (fall_stb) begin
                            shreg_ff <= {dat_sync_ff[1], shreg_ff[8:1]};
                            if (last_bit) begin
                                bit_cnt_ff <= 4'h0;
                                if (!cont_en_ff) begin
                                    rx_state_ff <= USR_RX_IDLE;
                                end
                            end else begin
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    end
                    default: begin
                        rx_state_ff <= USR_RX_IDLE;
                    end
                endcase
            end
        end
    end

    usr_rx_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .push      (push),
        .push_data (word_in),
        .pop       (rd_pop),
        .head      (fifo_head),
        .count     (fifo_count),
        .full      (fifo_full)
    );

    assign rx_done = (fifo_count != '0);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_irq_ff <= 1'b0;
        end else if (clk_en) begin
            rx_irq_ff <= rx_done && irq_ctl_ff[`USR_IC_RXIE]
                         && irq_ctl_ff[`USR_IC_PERIE]
                         && irq_ctl_ff[`USR_IC_GLBIE];
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_lane  = do_write && wr_strb_ff[0];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_ctl_ff    <= `USR_TXCTL_RST;
            port_en_ff   <= 1'b0;
            rx_nine_ff   <= 1'b0;
            single_en_ff <= 1'b0;
            cont_en_ff   <= 1'b0;
            baud_div_ff <= `USR_BAUD_RST;
            irq_ctl_ff  <= 3'h0;
            port_dir_ff <= `USR_PORTDIR_RST;
        end else if (clk_en) begin
            if (wr_lane && wr_addr_ff == `USR_TXCTL_OFFSET) begin
                tx_ctl_ff <= wr_data_ff[7:0];
                // no transmit datapath here, so the shifter is always empty
                tx_ctl_ff[`USR_TX_EMPTY] <= 1'b1;
                tx_ctl_ff[`USR_TX_RSVD]  <= 1'b0;
            end
            if (wr_lane && wr_addr_ff == `USR_RXCTL_OFFSET) begin
                port_en_ff   <= wr_data_ff[`USR_RC_PORTEN];
                rx_nine_ff   <= wr_data_ff[`USR_RC_NINE];
                single_en_ff <= wr_data_ff[`USR_RC_SINGLE];
                cont_en_ff   <= wr_data_ff[`USR_RC_CONT];
            end else if (word_end && !cont_en_ff) begin
                single_en_ff <= 1'b0;
            end
            if (wr_lane && wr_addr_ff == `USR_BAUD_OFFSET) begin
                baud_div_ff <= wr_data_ff[7:0];
            end
            if (wr_lane && wr_addr_ff == `USR_IRQCTL_OFFSET) begin
                irq_ctl_ff <= wr_data_ff[2:0];
            end
            if (wr_lane && wr_addr_ff == `USR_PORTDIR_OFFSET) begin
                port_dir_ff <= wr_data_ff[7:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            overrun_ff <= 1'b0;
        end else if (clk_en) begin
            if (word_end && fifo_full) begin
                overrun_ff <= 1'b1;
            end else if (!cont_en_ff) begin
                overrun_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_nine_bit_mode_ff   <= 1'b0;
            tx_ninth_bit_value_ff <= 1'b0;
        end else if (clk_en) begin
            tx_nine_bit_mode_ff   <= tx_ctl_ff[`USR_TX_NINE];
            tx_ninth_bit_value_ff <= tx_ctl_ff[`USR_TX_NINTHV];
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_pop  = ar_take && s_axi_araddr == `USR_RXDATA_OFFSET && rx_done;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `USR_TXCTL_OFFSET:   rd_mux[7:0] = tx_ctl_ff;
            `USR_RXCTL_OFFSET:   rd_mux[7:0] = {port_en_ff, rx_nine_ff, single_en_ff,
                                                cont_en_ff, 2'h0, overrun_ff,
                                                fifo_head[8]};
            `USR_RXDATA_OFFSET:  rd_mux[7:0] = fifo_head[7:0];
            `USR_BAUD_OFFSET:    rd_mux[7:0] = baud_div_ff;
            `USR_IRQCTL_OFFSET:  rd_mux[7:0] = {4'h0, rx_done, irq_ctl_ff};
            `USR_PORTDIR_OFFSET: rd_mux[7:0] = port_dir_ff;
            default:             rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `USR_RESP_OKAY;
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            wr_addr_ff    <= 8'h00;
            wr_data_ff    <= 32'h0000_0000;
            wr_strb_ff    <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff    <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr_ff    <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff    <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data_ff   <= s_axi_wdata;
                wr_strb_ff   <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_ff    <= 1'b0;
                w_held_ff     <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid  <= 1'b1;
                case (wr_addr_ff)
                    `USR_TXCTL_OFFSET, `USR_RXCTL_OFFSET, `USR_RXDATA_OFFSET,
                    `USR_BAUD_OFFSET, `USR_IRQCTL_OFFSET, `USR_PORTDIR_OFFSET:
                        s_axi_bresp <= `USR_RESP_OKAY;
                    default:
                        s_axi_bresp <= `USR_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `USR_RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_hit ? `USR_RESP_OKAY : `USR_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_end_full;
        clk_en && word_end && fifo_full;
    endsequence

    sequence s_end_single;
        clk_en && word_end && !cont_en_ff && !(wr_lane && wr_addr_ff == `USR_RXCTL_OFFSET);
    endsequence

    a_pin_release: assert property (clk_en && !port_ok |=> clock_line_pin_oe_n_ff)
        else $error("clock pin driven while port not owned");
    a_fall_sample: assert property (clk_en && fall_stb && master
                                    |=> !clock_line_pin_out_ff)
        else $error("master sample not on falling clock");
    a_single_stop: assert property (s_end_single
                                    |=> !single_en_ff ##1 rx_state_ff == USR_RX_IDLE)
        else $error("single reception did not stop");
    a_cont_keeps: assert property (clk_en && word_end && cont_en_ff && !overrun_ff && !fifo_full
                                   && !do_write |=> rx_state_ff == USR_RX_SHIFT)
        else $error("continuous reception stopped");
    a_push_done: assert property (clk_en && push && !rd_pop |=> rx_done)
        else $error("done flag not set after word stored");
    a_overrun_set: assert property (s_end_full |=> overrun_ff)
        else $error("overrun not flagged");
    a_overrun_block: assert property (overrun_ff |-> !push)
        else $error("transfer into fifo during overrun");
    a_overrun_hold: assert property (overrun_ff && cont_en_ff |=> overrun_ff)
        else $error("overrun cleared without clearing continuous enable");
    a_irq_gate: assert property (rx_irq_ff
                                 |-> $past(irq_ctl_ff[`USR_IC_GLBIE]) && $past(rx_done))
        else $error("irq raised without global enable");

endmodule : usr_sync_rx

// ### usr_defines.svh
/*
 * register offsets, field positions, reset values and bus answers of the
 * synchronous serial port.
 * assumes: included by bare name; byte addresses on an 8-bit AXI4-Lite
 * address, each register in the low byte of an aligned word.
 */
`ifndef USR_DEFINES_SVH
`define USR_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define USR_TXCTL_OFFSET   8'h98
`define USR_RXCTL_OFFSET   8'h18
`define USR_RXDATA_OFFSET  8'h1c
`define USR_BAUD_OFFSET    8'h20
`define USR_IRQCTL_OFFSET  8'h24
`define USR_PORTDIR_OFFSET 8'h28

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define USR_TX_MASTER 7
`define USR_TX_NINE   6
`define USR_TX_TXON   5
`define USR_TX_SYNC   4
`define USR_TX_RSVD   3
`define USR_TX_HIBAUD 2
`define USR_TX_EMPTY  1
`define USR_TX_NINTHV 0
`define USR_RC_PORTEN 7
`define USR_RC_NINE   6
`define USR_RC_SINGLE 5
`define USR_RC_CONT   4
`define USR_RC_OVR    1
`define USR_RC_NINTHV 0
`define USR_IC_RXIE   0
`define USR_IC_PERIE  1
`define USR_IC_GLBIE  2
`define USR_IC_DONE   3
`define USR_PD_CLK  6
`define USR_PD_DAT  7

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define USR_TXCTL_RST   8'h02
`define USR_PORTDIR_RST 8'hff
`define USR_BAUD_RST    8'h00
`define USR_RESP_OKAY   2'h0
`define USR_RESP_SLVERR 2'h2

`endif

// ### usr_pkg.sv
/*
 * types shared by the synchronous serial port.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package usr_pkg;

    typedef enum logic [1:0] {
        USR_MODE_ASYNC,
        USR_MODE_SYNC_MASTER,
        USR_MODE_SYNC_SLAVE
    } usr_mode_type;

    typedef enum logic {
        USR_RX_IDLE,
        USR_RX_SHIFT
    } usr_rx_state_type;

endpackage : usr_pkg

// ### usr_rx_fifo.sv
/*
 * small receive fifo holding data word and ninth bit together.
 * assumes: push is never given while full; pop never while empty.
 */
module usr_rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic                       clk_en,
    input  wire logic                       push,
    input  wire logic [WIDTH-1:0]           push_data,
    input  wire logic                       pop,
    output logic      [WIDTH-1:0]           head,
    output logic      [$clog2(DEPTH+1)-1:0] count,
    output logic                            full
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [$clog2(DEPTH+1)-1:0] count_ff;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_ff @(posedge mclk) begin
        if (clk_en && push) begin
            mem_ff[wr_ptr_ff] <= push_data;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_ff <= bump(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= bump(rd_ptr_ff);
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

    assign head  = mem_ff[rd_ptr_ff];
    assign count = count_ff;
    assign full  = (count_ff == ($clog2(DEPTH+1))'(DEPTH));

endmodule : usr_rx_fifo

// ### usr_link_peer.sv
/* far-side serial peripheral for synchronous master reception.
   assumes: device drives the link clock; clock released means idle. */
module usr_link_peer (
    input  wire logic       mclk,
    input  wire logic       clk_line,
    input  wire logic       clk_oe_n,
    input  wire logic [8:0] word,
    input  wire logic [3:0] nbits,
    output logic            data
);
    logic [3:0] cnt = 4'h0;
    logic       clk_q = 1'b0;
    initial data = 1'b0;
    always @(posedge mclk) begin
        clk_q <= clk_line;
        if (clk_oe_n) begin
            data <= ~data;  // released line wanders, never holds the last bit
            cnt  <= 4'h0;
        end else if (clk_line && !clk_q) begin
            data <= word[cnt];  // lsb first, stable across the falling edge
            cnt  <= (cnt == nbits - 4'h1) ? 4'h0 : cnt + 4'h1;
        end
    end
endmodule : usr_link_peer

// ### test_usr_sync_rx.sv
/* self-checking bench of the synchronous receiver over AXI4-Lite.
   assumes: usr_defines.svh, usr_sync_rx and usr_link_peer compiled. */
`include "usr_defines.svh"
module test_usr_sync_rx;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, sys_rst, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, clk_oe_n, dat_out, dat_oe_n, irq, t9m, t9v, ldat;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb, nbits;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [8:0]  word;
    logic        clk_out;
    int          err_total, tests_run;
    wire clk_w = clk_oe_n ? 1'b0 : clk_out;
    wire dat_w = dat_oe_n ? ldat : dat_out;
    usr_sync_rx dut (.mclk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_line_pin_in(clk_w),
        .clock_line_pin_out_ff(clk_out), .clock_line_pin_oe_n_ff(clk_oe_n),
        .data_line_pin_in(dat_w), .data_line_pin_out_ff(dat_out),
        .data_line_pin_oe_n_ff(dat_oe_n), .rx_irq_ff(irq), .tx_nine_bit_mode_ff(t9m),
        .tx_ninth_bit_value_ff(t9v));
    usr_link_peer peer (.mclk, .clk_line(clk_w), .clk_oe_n, .word, .nbits, .data(ldat));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rdat = s_axi_rdata;
        rsp  = s_axi_rresp;
    endtask : rd
    task rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdat, exp);
    endtask : rc
    task results;
        $display("errors %0d, checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    initial begin
        #200000;
        err_total++;
        results;
    end
    initial begin
        {sys_rst, clk_en, s_axi_wstrb, word, nbits} = {1'b1, 1'b1, 4'hf, 9'h05a, 4'h8};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {err_total, tests_run} = 0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rc(`USR_TXCTL_OFFSET, 32'h02);
        rc(`USR_PORTDIR_OFFSET, 32'hff);
        rd(8'h40);
        chk({30'h0, rsp}, {30'h0, `USR_RESP_SLVERR});
        wr(8'h40, 32'h01);
        chk({30'h0, rsp}, {30'h0, `USR_RESP_SLVERR});
        wr(`USR_TXCTL_OFFSET, 32'hff);
        chk({30'h0, rsp}, {30'h0, `USR_RESP_OKAY});
        rc(`USR_TXCTL_OFFSET, 32'hf7);
        chk({30'h0, t9m, t9v}, 32'h3);
        wr(`USR_TXCTL_OFFSET, 32'h90);
        wr(`USR_BAUD_OFFSET, 32'h03);  // 160 ns link clock
        wr(`USR_IRQCTL_OFFSET, 32'h07);
        wr(`USR_RXCTL_OFFSET, 32'ha0);
        for (int n = 0; n < 60 && !rdat[3]; n++) rd(`USR_IRQCTL_OFFSET);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, clk_oe_n}, 32'h0);
        chk({30'h0, dat_oe_n, dat_out}, 32'h2);
        rc(`USR_RXCTL_OFFSET, 32'h80);
        rc(`USR_RXDATA_OFFSET, 32'h5a);
        rc(`USR_IRQCTL_OFFSET, 32'h07);
        chk({31'h0, irq}, 32'h0);
        word  <= 9'h1a5;
        nbits <= 4'h9;
        wr(`USR_RXCTL_OFFSET, 32'hd0);
        repeat (400) @(posedge mclk);
        rc(`USR_RXCTL_OFFSET, 32'hd3);
        rc(`USR_RXDATA_OFFSET, 32'ha5);
        rc(`USR_RXCTL_OFFSET, 32'hd3);
        rc(`USR_RXDATA_OFFSET, 32'ha5);
        repeat (200) @(posedge mclk);
        rc(`USR_IRQCTL_OFFSET, 32'h07);
        wr(`USR_RXCTL_OFFSET, 32'hc0);
        rd(`USR_RXCTL_OFFSET);
        chk(rdat & 32'hfe, 32'hc0);
        wr(`USR_RXCTL_OFFSET, 32'hf0);
        repeat (400) @(posedge mclk);
        rd(`USR_RXCTL_OFFSET);
        chk(rdat & 32'h02, 32'h02);
        results;
    end
endmodule : test_usr_sync_rx
